// ### hdl/bstc_top.v
// What this block does
// - set select bit makes sink independent; clear bit follows group backlight lit state.
// - select bits 6..0 are sinks 7..1; bit 7 reserved.
// - pwm-enable set lets external pwm scale that sink's current.
// - pwm-enable clear ignores pwm; bits 6..0 sinks 7..1, bit 7 reserved.
// - off timeout expiry turns backlight off; 7-bit field bits 6..0.
// - with dim timeout enabled, off timeout counts only after dim expires.
// - off code zero disables; code N means N seconds, up to 127.
// - dim timeout expiry sets backlight to dim current; 7-bit field.
// - dim count starts once backlight reaches maximum current.
// - dim code zero disables; code N means N seconds, up to 127.
// - fade register holds fade-out rate high nibble, fade-in low nibble.
// - fade-out code zero changes level instantly, otherwise fades at rate.
`timescale 1ns/1ps
`default_nettype none
`include "bstc_defines.vh"

module bstc_top #(
    parameter SECOND_CYCLES = `BSTC_SECOND_CYCLES
) (
    input  wire       clk_sys_in,                  // 40 MHz system clock
    input  wire       sys_rst_in,                  // async reset, active high
    input  wire [7:0] reg_addr_in,                 // register offset
    input  wire [7:0] reg_wdata_in,                // write data
    input  wire       reg_wr_in,                   // write strobe, one cycle
    input  wire       reg_rd_in,                   // read strobe, one cycle
    output reg  [7:0] reg_rdata_out,               // read data, next cycle
    input  wire       backlight_group_enable_in,   // shared backlight enable
    input  wire       at_max_current_in,           // backlight reached max current
    input  wire [6:0] sink_enable_in,              // own enables of independent sinks
    input  wire       pwm_in,                      // external pwm pin
    output reg  [6:0] sink_on_out,                 // sink current switched on
    output reg  [6:0] sink_drive_out,              // sink drive after pwm scaling
    output reg        backlight_on_out,            // group backlight lit
    output reg        backlight_dim_out,           // group at dim current
    output reg        backlight_fading_out,        // fade toward dim or off requested
    output reg  [3:0] fade_out_rate_out,           // fade-out rate code
    output reg  [3:0] fade_in_rate_out             // fade-in rate code
);

    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_RAMP = 5'b00010;
    localparam [4:0] ST_MAX  = 5'b00100;
    localparam [4:0] ST_DIM  = 5'b01000;
    localparam [4:0] ST_OFF  = 5'b10000;

    localparam [31:0] SEC_LAST = SECOND_CYCLES - 1;

    reg [6:0] sink_sel_q;
    reg [6:0] pwm_scale_q;
    reg [6:0] off_secs_q;
    reg [6:0] dim_secs_q;
    reg [7:0] fade_rates_q;

    reg       pwm_meta_q;
    reg       pwm_sync_q;
    reg       en_meta_q;
    reg       en_sync_q;
    reg       max_meta_q;
    reg       max_sync_q;

    reg [4:0] state_q;
    reg [4:0] state_d;
    reg [31:0] presc_q;
    reg        tick_q;

    wire wr_off  = reg_wr_in && (reg_addr_in == `BSTC_ADDR_BACKLIGHT_OFF_TIMER);
    wire wr_dim  = reg_wr_in && (reg_addr_in == `BSTC_ADDR_BACKLIGHT_DIM_TIMER);
    wire dim_on  = (dim_secs_q != 7'h00);
    wire off_on  = (off_secs_q != 7'h00);

    // restarts when a count is rewritten or when its phase begins
    wire enter_max   = (state_d == ST_MAX) && (state_q != ST_MAX);
    wire enter_dim   = (state_d == ST_DIM) && (state_q != ST_DIM);
    wire dim_restart = wr_dim || enter_max;
    wire off_restart = wr_off || enter_dim || (enter_max && !dim_on);
    wire dim_run     = (state_q == ST_MAX);
    wire off_run     = (state_q == ST_DIM) || ((state_q == ST_MAX) && !dim_on);
    wire dim_expired;
    wire off_expired;

    // register writes; reserved bits are not stored
    always @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            sink_sel_q   <= `BSTC_RST_SINK_GROUP_SELECT;
            pwm_scale_q  <= `BSTC_RST_PWM_SCALE_ENABLE;
            off_secs_q   <= `BSTC_RST_OFF_TIMEOUT;
            dim_secs_q   <= `BSTC_RST_DIM_TIMEOUT;
            fade_rates_q <= `BSTC_RST_FADE_RATES;
        end
        else if (reg_wr_in)
        begin
            case (reg_addr_in)
                `BSTC_ADDR_SINK_GROUP_SELECT:
                    sink_sel_q <= reg_wdata_in[`BSTC_SINK_MSB:`BSTC_SINK_LSB];
                `BSTC_ADDR_PWM_SCALE_ENABLE:
                    pwm_scale_q <= reg_wdata_in[`BSTC_SINK_MSB:`BSTC_SINK_LSB];
                `BSTC_ADDR_BACKLIGHT_OFF_TIMER:
                    off_secs_q <= reg_wdata_in[`BSTC_TIMEOUT_MSB:`BSTC_TIMEOUT_LSB];
                `BSTC_ADDR_BACKLIGHT_DIM_TIMER:
                    dim_secs_q <= reg_wdata_in[`BSTC_TIMEOUT_MSB:`BSTC_TIMEOUT_LSB];
                `BSTC_ADDR_BACKLIGHT_FADE_RATES:
                    fade_rates_q <= reg_wdata_in;
                default:
                    sink_sel_q <= sink_sel_q;
            endcase
        end
    end

    // read data registered; reserved bit 7 and unmapped offsets read zero
    always @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            reg_rdata_out <= 8'h00;
        else if (reg_rd_in)
        begin
            case (reg_addr_in)
                `BSTC_ADDR_SINK_GROUP_SELECT:    reg_rdata_out <= {1'b0, sink_sel_q};
                `BSTC_ADDR_PWM_SCALE_ENABLE:     reg_rdata_out <= {1'b0, pwm_scale_q};
                `BSTC_ADDR_BACKLIGHT_OFF_TIMER:  reg_rdata_out <= {1'b0, off_secs_q};
                `BSTC_ADDR_BACKLIGHT_DIM_TIMER:  reg_rdata_out <= {1'b0, dim_secs_q};
                `BSTC_ADDR_BACKLIGHT_FADE_RATES: reg_rdata_out <= fade_rates_q;
                default:                         reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // pins from outside the clock domain
    always @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            pwm_meta_q <= 1'b0;
            pwm_sync_q <= 1'b0;
            en_meta_q  <= 1'b0;
            en_sync_q  <= 1'b0;
            max_meta_q <= 1'b0;
            max_sync_q <= 1'b0;
        end
        else
        begin
            pwm_meta_q <= pwm_in;
            pwm_sync_q <= pwm_meta_q;
            en_meta_q  <= backlight_group_enable_in;
            en_sync_q  <= en_meta_q;
            max_meta_q <= at_max_current_in;
            max_sync_q <= max_meta_q;
        end
    end

    // prescaler realigns on every timer restart so a timeout is a full N seconds
    always @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            presc_q <= 32'h0000_0000;
            tick_q  <= 1'b0;
        end
        else if (dim_restart || off_restart)
        begin
            presc_q <= 32'h0000_0000;
            tick_q  <= 1'b0;
        end
        else if (presc_q == SEC_LAST)
        begin
            presc_q <= 32'h0000_0000;
            tick_q  <= 1'b1;
        end
        else
        begin
            presc_q <= presc_q + 32'h0000_0001;
            tick_q  <= 1'b0;
        end
    end

    bstc_sec_timer #(
        .W (7)
    ) u_dim_timer (
        .clk_sys_in  (clk_sys_in),
        .sys_rst_in  (sys_rst_in),
        .restart_in  (dim_restart),
        .run_in      (dim_run),
        .tick_in     (tick_q),
        .seconds_in  (dim_secs_q),
        .expired_out (dim_expired),
        .armed_out   ()
    );

    bstc_sec_timer #(
        .W (7)
    ) u_off_timer (
        .clk_sys_in  (clk_sys_in),
        .sys_rst_in  (sys_rst_in),
        .restart_in  (off_restart),
        .run_in      (off_run),
        .tick_in     (tick_q),
        .seconds_in  (off_secs_q),
        .expired_out (off_expired),
        .armed_out   ()
    );

    // group backlight sequence
    always @*
    begin
        state_d = state_q;
        if (!en_sync_q)
            state_d = ST_IDLE;
        else
        begin
            case (state_q)
                ST_IDLE: state_d = ST_RAMP;
                ST_RAMP:
                    if (max_sync_q)
                        state_d = ST_MAX;
                ST_MAX:
                    if (dim_on && dim_expired)
                        state_d = ST_DIM;
                    else if (!dim_on && off_expired)
                        state_d = ST_OFF;
                ST_DIM:
                    if (off_expired)
                        state_d = ST_OFF;
                ST_OFF:  state_d = ST_OFF;
                default: state_d = ST_IDLE;
            endcase
        end
    end

    always @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // outputs
    always @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            sink_on_out          <= 7'h00;
            sink_drive_out       <= 7'h00;
            backlight_on_out     <= 1'b0;
            backlight_dim_out    <= 1'b0;
            backlight_fading_out <= 1'b0;
            fade_out_rate_out    <= 4'h0;
            fade_in_rate_out     <= 4'h0;
        end
        else
        begin
            backlight_on_out  <= (state_q == ST_RAMP) || (state_q == ST_MAX) || (state_q == ST_DIM);
            backlight_dim_out <= (state_q == ST_DIM);
            // nonzero fade-out rate holds the fade flag while heading to dim or off
            backlight_fading_out <= ((state_q == ST_DIM) || (state_q == ST_OFF))
                && (fade_rates_q[`BSTC_FADE_OUT_MSB:`BSTC_FADE_OUT_LSB] != `BSTC_FADE_DISABLED);
            fade_out_rate_out <= fade_rates_q[`BSTC_FADE_OUT_MSB:`BSTC_FADE_OUT_LSB];
            fade_in_rate_out  <= fade_rates_q[`BSTC_FADE_IN_MSB:`BSTC_FADE_IN_LSB];
            sink_on_out <= (sink_sel_q & sink_enable_in)
                | (~sink_sel_q & {7{backlight_on_out}});
            // unscaled sinks ignore the pwm pin entirely
            sink_drive_out <= sink_on_out & (~pwm_scale_q | {7{pwm_sync_q}});
        end
    end

endmodule

`default_nettype wire

// ### hdl/bstc_defines.vh
`ifndef BSTC_DEFINES_VH
`define BSTC_DEFINES_VH

// register offsets on the host register port
`define BSTC_ADDR_SINK_GROUP_SELECT     8'h05
`define BSTC_ADDR_PWM_SCALE_ENABLE      8'h06
`define BSTC_ADDR_BACKLIGHT_OFF_TIMER   8'h07
`define BSTC_ADDR_BACKLIGHT_DIM_TIMER   8'h08
`define BSTC_ADDR_BACKLIGHT_FADE_RATES  8'h09

// field positions
`define BSTC_SINK_MSB                   6
`define BSTC_SINK_LSB                   0
`define BSTC_TIMEOUT_MSB                6
`define BSTC_TIMEOUT_LSB                0
`define BSTC_FADE_OUT_MSB               7
`define BSTC_FADE_OUT_LSB               4
`define BSTC_FADE_IN_MSB                3
`define BSTC_FADE_IN_LSB                0

// reset values
`define BSTC_RST_SINK_GROUP_SELECT      7'h00
`define BSTC_RST_PWM_SCALE_ENABLE       7'h00
`define BSTC_RST_OFF_TIMEOUT            7'h00
`define BSTC_RST_DIM_TIMEOUT            7'h00
`define BSTC_RST_FADE_RATES             8'h00
`define BSTC_FADE_DISABLED              4'h0

// timing
`define BSTC_CLK_KHZ                    40000
`define BSTC_SECOND_MS                  1000
`define BSTC_SECOND_CYCLES              (`BSTC_SECOND_MS * `BSTC_CLK_KHZ)

`endif

// ### hdl/bstc_sec_timer.v
`timescale 1ns/1ps
`default_nettype none

// counts whole seconds of tick pulses; zero seconds means disabled
module bstc_sec_timer #(
    parameter W = 7
) (
    input  wire         clk_sys_in,   // system clock
    input  wire         sys_rst_in,   // async reset, active high
    input  wire         restart_in,   // reload and clear elapsed count
    input  wire         run_in,       // count only while high
    input  wire         tick_in,      // one-second enable pulse
    input  wire [W-1:0] seconds_in,   // timeout in seconds, 0 = off
    output reg          expired_out,  // one-cycle pulse at timeout
    output wire         armed_out     // timer loaded with nonzero time
);

    reg  [W-1:0] elapsed_q;
    reg          armed_q;
    wire [W-1:0] elapsed_inc = elapsed_q + {{(W-1){1'b0}}, 1'b1};

    assign armed_out = armed_q;

    always @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            elapsed_q   <= {W{1'b0}};
            armed_q     <= 1'b0;
            expired_out <= 1'b0;
        end
        else
        begin
            expired_out <= 1'b0;
            if (restart_in)
            begin
                elapsed_q <= {W{1'b0}};
                armed_q   <= (seconds_in != {W{1'b0}});
            end
            else if (armed_q && run_in && tick_in)
            begin
                if (elapsed_inc == seconds_in)
                begin
                    expired_out <= 1'b1;
                    armed_q     <= 1'b0;
                end
                elapsed_q <= elapsed_inc;
            end
        end
    end

endmodule

`default_nettype wire

// ### verif/bstc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module bstc_chk (
    input wire logic       clk_sys_in,                // clock
    input wire logic       sys_rst_in,                // reset
    input wire logic [7:0] reg_addr_in,               // offset
    input wire logic [7:0] reg_wdata_in,              // wdata
    input wire logic       reg_wr_in,                 // write
    input wire logic       reg_rd_in,                 // read
    input wire logic [7:0] reg_rdata_out,             // rdata
    input wire logic       backlight_group_enable_in, // enable
    input wire logic       at_max_current_in,         // at max
    input wire logic [6:0] sink_enable_in,            // own on
    input wire logic       pwm_in,                    // pwm
    input wire logic [6:0] sink_on_out,               // on
    input wire logic [6:0] sink_drive_out,            // drive
    input wire logic       backlight_on_out,          // lit
    input wire logic       backlight_dim_out,         // dim
    input wire logic       backlight_fading_out,      // fading
    input wire logic [3:0] fade_out_rate_out,         // fade out
    input wire logic [3:0] fade_in_rate_out           // fade in
);
    logic [6:0] sel_q, scl_q, off_q, dim_q;
    logic [7:0] fade_q, rd_exp;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    // write shadows, so no internal taps are needed
    always @(posedge clk_sys_in or posedge sys_rst_in)
        if (sys_rst_in)
        begin
            {sel_q, scl_q, off_q, dim_q, fade_q} <= 36'h0;
        end
        else if (reg_wr_in)
        begin
            if (reg_addr_in == 8'h05) sel_q <= reg_wdata_in[6:0];
            if (reg_addr_in == 8'h06) scl_q <= reg_wdata_in[6:0];
            if (reg_addr_in == 8'h07) off_q <= reg_wdata_in[6:0];
            if (reg_addr_in == 8'h08) dim_q <= reg_wdata_in[6:0];
            if (reg_addr_in == 8'h09) fade_q <= reg_wdata_in;
        end
    assign rd_exp = reg_addr_in == 8'h05 ? {1'b0, sel_q} : reg_addr_in == 8'h06 ? {1'b0, scl_q} :
                    reg_addr_in == 8'h07 ? {1'b0, off_q} : reg_addr_in == 8'h08 ? {1'b0, dim_q} :
                    reg_addr_in == 8'h09 ? fade_q : 8'h00;
    sequence s_en_up;
        $rose(backlight_group_enable_in) ##1 backlight_group_enable_in [*3];
    endsequence
    sequence s_en_down;
        $fell(backlight_group_enable_in) ##1 !backlight_group_enable_in [*3];
    endsequence
    property p_sink_sel;
        sink_on_out == $past((sel_q & sink_enable_in) | (~sel_q & {7{backlight_on_out}}));
    endproperty
    a_sink_sel: assert property (p_sink_sel) else $error("sink on mismatch");
    property p_drive;
        sink_drive_out == ($past(sink_on_out) & (~$past(scl_q) | {7{$past(pwm_in, 3)}}));
    endproperty
    a_drive: assert property (p_drive) else $error("sink drive mismatch");
    property p_rd;
        reg_rd_in |=> reg_rdata_out == $past(rd_exp);
    endproperty
    a_rd: assert property (p_rd) else $error("read data mismatch");
    property p_fade;
        reg_wr_in && reg_addr_in == 8'h09 ##1 !reg_wr_in |-> ##[0:1] {fade_out_rate_out, fade_in_rate_out} == fade_q;
    endproperty
    a_fade: assert property (p_fade) else $error("fade nibbles mismatch");
    property p_en_up;
        s_en_up |=> backlight_on_out;
    endproperty
    a_en_up: assert property (p_en_up) else $error("backlight not lit");
    property p_en_down;
        s_en_down |=> !backlight_on_out && !backlight_dim_out;
    endproperty
    a_en_down: assert property (p_en_down) else $error("backlight not idle");
    property p_dim_lit;
        backlight_dim_out |-> backlight_on_out;
    endproperty
    a_dim_lit: assert property (p_dim_lit) else $error("dim while dark");
    property p_dim_zero;
        $rose(backlight_dim_out) |-> dim_q != 7'h00;
    endproperty
    a_dim_zero: assert property (p_dim_zero) else $error("dim with timer off");
    property p_off_zero;
        $fell(backlight_on_out) && off_q == 7'h00 |-> !$past(backlight_group_enable_in, 4);
    endproperty
    a_off_zero: assert property (p_off_zero) else $error("off with timer off");
    property p_off_dim;
        $fell(backlight_on_out) && dim_q != 7'h00 && $past(backlight_group_enable_in, 4) |-> $past(backlight_dim_out);
    endproperty
    a_off_dim: assert property (p_off_dim) else $error("off before dim");
    property p_fade_flag;
        backlight_fading_out |-> fade_out_rate_out != 4'h0 && (backlight_dim_out || !backlight_on_out);
    endproperty
    a_fade_flag: assert property (p_fade_flag) else $error("fade flag mismatch");
endmodule
bind bstc_top bstc_chk u_chk (.*);
`default_nettype wire

// ### verif/bstc_pwm_src.sv
`timescale 1ns/1ps
`default_nettype none
module bstc_pwm_src (
    input  wire logic clk_sys_in, // clock
    input  wire logic sys_rst_in, // reset
    output var  logic pwm_out     // pwm pin
);
    logic [2:0] cnt_q;
    // 3 of 8 duty, so a stuck or inverted gate shows in the count
    always @(posedge clk_sys_in or posedge sys_rst_in)
        if (sys_rst_in)
        begin
            cnt_q   <= 3'h0;
            pwm_out <= 1'b0;
        end
        else
        begin
            cnt_q   <= cnt_q + 3'h1;
            pwm_out <= cnt_q < 3'h3;
        end
endmodule
`default_nettype wire

// ### verif/bstc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module bstc_top_tb_top;
    localparam int SC = 10;
    logic       clk_sys_in = 1'b0;
    logic       sys_rst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic       reg_wr_in = 1'b0;
    logic       reg_rd_in = 1'b0;
    logic       backlight_group_enable_in = 1'b0;
    logic       at_max_current_in = 1'b0;
    logic [6:0] sink_enable_in = 7'h00;
    logic       rd_q = 1'b0;
    logic [7:0] d;
    logic [6:0] s;
    logic [7:0] exp_q[$];
    wire  [7:0] reg_rdata_out;
    wire  [6:0] sink_on_out, sink_drive_out;
    wire  [3:0] fade_out_rate_out, fade_in_rate_out;
    wire        pwm_in, backlight_on_out, backlight_dim_out, backlight_fading_out;
    int         bad_count = 0, samples_checked = 0, seed = 32'h247d, cyc = 0, n;
    bstc_top #(.SECOND_CYCLES(SC)) u_dut (.*);
    bstc_pwm_src u_pwm (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .pwm_out(pwm_in));
    initial
    begin
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        samples_checked++;
        if (got !== ex)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys_in);
        reg_addr_in  <= a;
        reg_wdata_in <= v;
        reg_wr_in    <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        exp_q.push_back(ex);
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
    endtask
    // w selects lit (1) or dim (0); counts edges until it reaches lvl
    task automatic wait_for(input int w, input logic lvl, output int k);
        k = 0;
        while ((w ? backlight_on_out : backlight_dim_out) !== lvl && k < 3000)
        begin
            @(posedge clk_sys_in);
            #1;
            k++;
        end
    endtask
    task automatic in_rng(input string nm, input int lo, input int hi, input int got);
        chk(nm, 8'h01, {7'h0, got >= lo && got <= hi});
    endtask
    always @(posedge clk_sys_in)
    begin
        rd_q <= reg_rd_in;
        cyc  <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            complete_run;
        end
    end
    always @(negedge clk_sys_in)
        if (rd_q)
            chk("rdata", exp_q.pop_front(), reg_rdata_out);
    initial
    begin
        repeat (12) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        for (int a = 5; a <= 9; a++)
        begin
            rd(8'(a), 8'h00);
            d = 8'($random(seed));
            wr(8'(a), d);
            rd(8'(a), (a == 9) ? d : {1'b0, d[6:0]});
        end
        wr(8'h0a, 8'hff);
        rd(8'h0a, 8'h00);
        $display("test registers done");
        wr(8'h06, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            s = 7'($random(seed));
            wr(8'h05, {1'b0, s});
            @(posedge clk_sys_in);
            sink_enable_in            <= 7'($random(seed));
            backlight_group_enable_in <= i[0];
            repeat (8) @(posedge clk_sys_in);
            #1;
            chk("sink_on", {1'b0, (s & sink_enable_in) | (~s & {7{i[0]}})}, {1'b0, sink_on_out});
            chk("drive", {1'b0, sink_on_out}, {1'b0, sink_drive_out});
        end
        @(posedge clk_sys_in);
        sink_enable_in <= 7'h7f;
        wr(8'h06, 8'h7f);
        repeat (8) @(posedge clk_sys_in);
        n = 0;
        repeat (8)
        begin
            @(posedge clk_sys_in);
            #1;
            n += (sink_drive_out === sink_on_out);
        end
        chk("pwm duty", 8'h03, 8'(n));
        $display("test sinks done");
        @(posedge clk_sys_in);
        backlight_group_enable_in <= 1'b0;
        wr(8'h09, 8'h30);
        wr(8'h08, 8'h02);
        wr(8'h07, 8'h03);
        backlight_group_enable_in <= 1'b1;
        repeat (5 * SC) @(posedge clk_sys_in);
        #1;
        chk("dim before max", 8'h00, {7'h0, backlight_dim_out});
        chk("fade rates", 8'h30, {fade_out_rate_out, fade_in_rate_out});
        @(posedge clk_sys_in);
        at_max_current_in <= 1'b1;
        wait_for(0, 1'b1, n);
        in_rng("dim time", 2 * SC + 2, 2 * SC + 8, n);
        @(posedge clk_sys_in);
        #1;
        chk("fading", 8'h01, {7'h0, backlight_fading_out});
        wait_for(1, 1'b0, n);
        in_rng("off time", 3 * SC - 1, 3 * SC + 4, n);
        repeat (20) @(posedge clk_sys_in);
        #1;
        chk("stays off", 8'h00, {7'h0, backlight_on_out});
        @(posedge clk_sys_in);
        backlight_group_enable_in <= 1'b0;
        at_max_current_in         <= 1'b0;
        wr(8'h08, 8'h00);
        wr(8'h07, 8'h02);
        wr(8'h09, 8'h00);
        backlight_group_enable_in <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        at_max_current_in <= 1'b1;
        repeat (SC + 5) @(posedge clk_sys_in);
        wr(8'h07, 8'h02);
        wait_for(1, 1'b0, n);
        in_rng("restart", 2 * SC, 2 * SC + 4, n);
        chk("no fade", 8'h00, {7'h0, backlight_fading_out});
        @(posedge clk_sys_in);
        backlight_group_enable_in <= 1'b0;
        wr(8'h07, 8'h00);
        backlight_group_enable_in <= 1'b1;
        repeat (30 * SC) @(posedge clk_sys_in);
        #1;
        chk("never off", 8'h03, {6'h0, backlight_on_out, ~backlight_dim_out});
        $display("test timers done");
        @(posedge clk_sys_in);
        sys_rst_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        rd(8'h07, 8'h00);
        repeat (4) @(posedge clk_sys_in);
        $display("test reset done");
        complete_run;
    end
endmodule
`default_nettype wire
